// File: inc/pc_stack_defs.svh
// constants for the program counter and return stack
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH
`define PC_WIDTH 13
`define PC_LOW_JUMP_BITS 12
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3
`define PAGE_BIT_POS 7
`define RESET_VECTOR 13'h0000
`define VEC_GROUP_A 13'h0006
`define VEC_GROUP_B 13'h0007
`endif

// File: inc/pc_stack_pkg.sv
// types shared by the program counter and return stack
package pc_stack_pkg;
   // sequencing operation requested by the decoder for one executed instruction
   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_STEP = 3'b001,
      OP_JUMP = 3'b010,
      OP_CALL = 3'b011,
      OP_RET = 3'b100,
      OP_RETLIT = 3'b101,
      OP_LOWWR = 3'b110
   } seq_op_t;
endpackage : pc_stack_pkg

// File: rtl/program_counter_call_stack.sv
// program counter and eight-level hardware return stack
`timescale 1ns/1ps
`default_nettype none
`include "pc_stack_defs.svh"
module program_counter_call_stack
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic EXEC_I,
   input wire pc_stack_pkg::seq_op_t OP_I,
   input wire logic [13:0] INSTR_I,
   input wire logic PROGRAM_PAGE_BIT_I,
   input wire logic [7:0] LOW_BYTE_I,
   input wire logic IRQ_ACCEPT_I,
   input wire logic IRQ_GROUP_B_I,
   output logic [12:0] PC_O,
   output logic [7:0] WREG_DATA_O,
   output logic WREG_LOAD_O
);
   import pc_stack_pkg::*;

   logic [12:0] pc_q;
   logic [12:0] pc_d;
   logic [12:0] stack_q [0:`STACK_DEPTH-1];
   logic [12:0] stack_d [0:`STACK_DEPTH-1];
   logic [2:0] sp_q;
   logic [2:0] sp_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic wload_q;
   logic wload_d;
   logic [12:0] top_entry;

   // pointer step with natural 3-bit wrap
   function automatic logic [2:0] ptr_step(input logic [2:0] p, input logic up);
      ptr_step = up ? 3'(p + 3'h1) : 3'(p - 3'h1);
   endfunction : ptr_step

   // top of stack is the entry below the write pointer
   assign top_entry = stack_q[ptr_step(sp_q, 1'b0)];

   // next-state: counter, stack and working-register load
   always_comb
   begin
      pc_d = pc_q;
      sp_d = sp_q;
      wdata_d = wdata_q;
      wload_d = 1'b0;
      for (int i = 0; i < `STACK_DEPTH; i++)
      begin
         stack_d[i] = stack_q[i];
      end
      if (IRQ_ACCEPT_I)
      begin
         // interrupt entry saves the current counter value pc_q, not incremented
         stack_d[sp_q] = pc_q;
         sp_d = ptr_step(sp_q, 1'b1);
         pc_d = IRQ_GROUP_B_I ? `VEC_GROUP_B : `VEC_GROUP_A;
      end
      else if (EXEC_I)
      begin
         case (OP_I)
            OP_STEP:
            begin
               pc_d = 13'(pc_q + 13'h0001);
            end
            OP_JUMP:
            begin
               pc_d = {PROGRAM_PAGE_BIT_I, INSTR_I[11:0]};
            end
            OP_CALL:
            begin
               stack_d[sp_q] = 13'(pc_q + 13'h0001);
               sp_d = ptr_step(sp_q, 1'b1);
               pc_d = {PROGRAM_PAGE_BIT_I, INSTR_I[11:0]};
            end
            OP_RET:
            begin
               pc_d = top_entry;
               sp_d = ptr_step(sp_q, 1'b0);
            end
            OP_RETLIT:
            begin
               pc_d = top_entry;
               sp_d = ptr_step(sp_q, 1'b0);
               wdata_d = INSTR_I[7:0];
               wload_d = 1'b1;
            end
            OP_LOWWR:
            begin
               pc_d = {pc_q[12:8], LOW_BYTE_I};
            end
            default:
            begin
               pc_d = pc_q;
            end
         endcase
      end
   end

   // registers; stack has no program or data path, only these ops reach it
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         pc_q <= `RESET_VECTOR;
         sp_q <= 3'h0;
         wdata_q <= 8'h00;
         wload_q <= 1'b0;
         for (int i = 0; i < `STACK_DEPTH; i++)
         begin
            stack_q[i] <= 13'h0000;
         end
      end
      else
      begin
         pc_q <= pc_d;
         sp_q <= sp_d;
         wdata_q <= wdata_d;
         wload_q <= wload_d;
         for (int i = 0; i < `STACK_DEPTH; i++)
         begin
            stack_q[i] <= stack_d[i];
         end
      end
   end

   assign PC_O = pc_q;
   assign WREG_DATA_O = wdata_q;
   assign WREG_LOAD_O = wload_q;

   // checks
   AST_STEP: assert property (@(posedge CLK_I) disable iff (RST_I)
      (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_STEP) |=> PC_O == 13'($past(PC_O) + 13'h0001))
      else $error("pc did not step by one");
   AST_JUMP: assert property (@(posedge CLK_I) disable iff (RST_I)
      (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_JUMP) |=> PC_O == {$past(PROGRAM_PAGE_BIT_I), $past(INSTR_I[11:0])})
      else $error("jump target wrong");
   AST_CALL_RET: assert property (@(posedge CLK_I) disable iff (RST_I)
      (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_CALL) ##1 (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_RET)
      |=> PC_O == 13'($past(PC_O, 2) + 13'h0001))
      else $error("return did not restore call address");
   AST_LOWWR: assert property (@(posedge CLK_I) disable iff (RST_I)
      (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_LOWWR) |=> PC_O[12:8] == $past(PC_O[12:8]) && PC_O[7:0] == $past(LOW_BYTE_I))
      else $error("low byte write disturbed high bits");
   AST_PUSH: assert property (@(posedge CLK_I) disable iff (RST_I)
      (IRQ_ACCEPT_I || (EXEC_I && OP_I == OP_CALL)) |=> sp_q == 3'($past(sp_q) + 3'h1))
      else $error("push did not advance pointer");
   AST_POP: assert property (@(posedge CLK_I) disable iff (RST_I)
      (!IRQ_ACCEPT_I && EXEC_I && (OP_I == OP_RET || OP_I == OP_RETLIT)) |=> sp_q == 3'($past(sp_q) - 3'h1))
      else $error("pop count wrong");
   AST_VEC_A: assert property (@(posedge CLK_I) disable iff (RST_I)
      (IRQ_ACCEPT_I && !IRQ_GROUP_B_I) |=> PC_O == 13'h0006)
      else $error("group a vector wrong");
   AST_VEC_B: assert property (@(posedge CLK_I) disable iff (RST_I)
      (IRQ_ACCEPT_I && IRQ_GROUP_B_I) |=> PC_O == 13'h0007)
      else $error("group b vector wrong");
   AST_RESET: assert property (@(posedge CLK_I)
      RST_I |=> PC_O == 13'h0000 && sp_q == 3'h0)
      else $error("reset vector wrong");
   AST_RETLIT: assert property (@(posedge CLK_I) disable iff (RST_I)
      (EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_RETLIT) |=> WREG_LOAD_O && WREG_DATA_O == $past(INSTR_I[7:0]))
      else $error("literal not delivered");
   AST_LOAD_PULSE: assert property (@(posedge CLK_I) disable iff (RST_I)
      WREG_LOAD_O |-> $past(EXEC_I && !IRQ_ACCEPT_I && OP_I == OP_RETLIT))
      else $error("working register load without literal return");
endmodule : program_counter_call_stack
`default_nettype wire

// File: tb/program_rom_model.sv
// program memory model feeding instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module program_rom_model
(
   input wire logic [12:0] pc_i,
   output logic [13:0] instr_o
);
   // every one of the 8k words has its own contents
   assign instr_o = {pc_i[0], pc_i ^ 13'h1a5b};
endmodule : program_rom_model
`default_nettype wire

// File: tb/program_counter_call_stack_tb.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module program_counter_call_stack_tb;
   import pc_stack_pkg::*;
   logic clk = 1'b0, rst = 1'b1, exec = 1'b0, page = 1'b0, irq = 1'b0, grp = 1'b0, took = 1'b0, seen = 1'b0;
   seq_op_t op = OP_NONE;
   logic [7:0] low = 8'h00, wreg = 8'h00, wd;
   logic [12:0] pc = 13'h0000, pc_o;
   logic [12:0] stk [8]; // eight entries of 13 bits
   logic [2:0] sp = 3'h0;
   logic [13:0] instr;
   logic wl;
   logic [21:0] expq [$];
   logic [31:0] rs = 32'h0001_33f6;
   int n_mismatch = 0, comparisons = 0;
   // core clock, 100 MHz
   always #5 clk = ~clk;
   program_counter_call_stack program_counter_call_stack_inst (.CLK_I(clk), .RST_I(rst), .EXEC_I(exec),
      .OP_I(op), .INSTR_I(instr), .PROGRAM_PAGE_BIT_I(page), .LOW_BYTE_I(low), .IRQ_ACCEPT_I(irq),
      .IRQ_GROUP_B_I(grp), .PC_O(pc_o), .WREG_DATA_O(wd), .WREG_LOAD_O(wl));
   program_rom_model program_rom_model_inst (.pc_i(pc_o), .instr_o(instr));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic check(input logic [21:0] s, input logic [21:0] e);
      comparisons++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // drive one cycle and note the expected counter and literal
   task automatic issue(input seq_op_t o, input logic e, input logic i, input logic g);
      logic ld, pg;
      logic [7:0] lo;
      logic [13:0] ins;
      @(posedge clk);
      // word the memory shows at the counter the op will see
      ins = {pc[0], pc ^ 13'h1a5b};
      rs = xs(rs);
      pg = rs[0];
      lo = rs[15:8];
      ld = 1'b0;
      if (i)
      begin
         stk[sp] = pc; // interrupt pushes, wraps on ninth
         sp = sp + 3'h1;
         pc = g ? 13'h0007 : 13'h0006;
      end
      else if (e)
         case (o)
            OP_STEP: pc = pc + 13'h0001;
            OP_LOWWR: pc = {pc[12:8], lo};
            OP_JUMP, OP_CALL:
            begin
               if (o == OP_CALL)
               begin
                  stk[sp] = pc + 13'h0001;
                  sp = sp + 3'h1;
               end
               pc = {pg, ins[11:0]};
            end
            OP_RET, OP_RETLIT:
            begin
               sp = sp - 3'h1; // one pop each
               pc = stk[sp];
               if (o == OP_RETLIT)
               begin
                  wreg = ins[7:0];
                  ld = 1'b1;
               end
            end
            default: ;
         endcase
      exec <= e;
      op <= o;
      page <= pg;
      low <= lo;
      irq <= i;
      grp <= g;
      took <= 1'b1;
      expq.push_back({ld, wreg, pc});
   endtask : issue
   // result of each op appears one edge later
   always @(posedge clk) seen <= took;
   always @(negedge clk)
      if (seen && expq.size() > 0)
         check({wl, wd, pc_o}, expq.pop_front()); // counter and literal
   // main sequence: wrap test, both vectors, then random ops
   initial
   begin
      for (int k = 0; k < 8; k++)
         stk[k] = 13'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      issue(OP_NONE, 1'b1, 1'b0, 1'b0);
      repeat (9) issue(OP_CALL, 1'b1, 1'b0, 1'b0);
      repeat (9) issue(OP_RET, 1'b1, 1'b0, 1'b0);
      issue(OP_STEP, 1'b1, 1'b1, 1'b1);
      issue(OP_CALL, 1'b1, 1'b1, 1'b0);
      issue(OP_RETLIT, 1'b1, 1'b0, 1'b0);
      repeat (400)
         issue(seq_op_t'(rs[18:16] % 3'd7), rs[19] | rs[20], rs[23:21] == 3'h0, rs[24]);
      @(posedge clk);
      took <= 1'b0;
      exec <= 1'b0;
      irq <= 1'b0;
      repeat (3) @(negedge clk);
      final_report();
   end
   // watchdog against a hang
   initial
   begin
      #100000;
      n_mismatch++;
      final_report();
   end
endmodule : program_counter_call_stack_tb
`default_nettype wire
